// [design/disk_cmd_pkg.sv]
// constants shared by the disk command decoder and its register file
// assumes a 40 MHz clock and an APB master with 32-bit data
package disk_cmd_pkg;

   // ************************************************
   // register map (byte addresses)
   // ************************************************
   localparam logic [7:0] ADDR_CMD_LO = 8'h00;
   localparam logic [7:0] ADDR_CMD_HI = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   localparam logic [7:0] ADDR_DONE = 8'h10;
   localparam logic [7:0] ADDR_SPT = 8'h14;
   localparam logic [7:0] ADDR_REPORT = 8'h18;
   localparam logic [7:0] SPT_RESET = 8'h11;

   // ************************************************
   // command classes, op codes, units
   // ************************************************
   localparam logic [2:0] CLASS_OPER = 3'h0;
   localparam logic [2:0] CLASS_DIAG = 3'h7;
   localparam logic [4:0] OP_TEST_READY = 5'h00;
   localparam logic [4:0] OP_RECAL = 5'h01;
   localparam logic [4:0] OP_STATUS = 5'h03;
   localparam logic [4:0] OP_FMT_DRIVE = 5'h04;
   localparam logic [4:0] OP_CHECK_FMT = 5'h05;
   localparam logic [4:0] OP_FMT_TRACK = 5'h06;
   localparam logic [4:0] OP_FMT_BAD = 5'h07;
   localparam logic [4:0] OP_READ = 5'h08;
   localparam logic [4:0] OP_WRITE = 5'h0A;
   localparam logic [4:0] OP_SEEK = 5'h0B;
   localparam logic [4:0] OP_SET_PARAM = 5'h0C;
   localparam logic [4:0] OP_BURST_LEN = 5'h0D;
   localparam logic [4:0] OP_FMT_ALT = 5'h0E;
   localparam logic [4:0] OP_BUF_WRITE = 5'h0F;
   localparam logic [4:0] OP_BUF_READ = 5'h10;
   localparam logic [4:0] DG_MEMORY = 5'h00;
   localparam logic [4:0] DG_DRIVE = 5'h03;
   localparam logic [4:0] DG_CTRL = 5'h04;
   localparam logic [4:0] DG_READ_EXT = 5'h05;
   localparam logic [4:0] DG_WRITE_EXT = 5'h06;
   localparam logic [2:0] FLEX_UNIT_A = 3'h4;
   localparam logic [2:0] FLEX_UNIT_B = 3'h5;

   // ************************************************
   // control byte fields, error codes, counts
   // ************************************************
   localparam int CTL_RETRY = 7;
   localparam int CTL_ECC = 6;
   localparam int CTL_FILL = 5;
   localparam int CTL_SS_LSB = 4;
   localparam logic [5:0] ERR_NONE = 6'h00;
   localparam logic [5:0] ERR_FAULT = 6'h03;
   localparam logic [5:0] ERR_NOT_READY = 6'h04;
   localparam logic [5:0] ERR_TRACK0 = 6'h06;
   localparam logic [5:0] ERR_SEEK_BUSY = 6'h08;
   localparam logic [5:0] ERR_INVALID = 6'h32;
   localparam logic [10:0] MAX_STEPS_FIXED = 11'h400;
   localparam logic [10:0] MAX_STEPS_FLEX = 11'h100;
   localparam logic [8:0] BLOCK_FULL = 9'h100;
   localparam int CLK_PERIOD_NS = 25;
   localparam int STEP_TIME_US = 3000;
   localparam int STEP_CYCLES = STEP_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int STEP_PULSE_NS = 1000;
   localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {st_idle, st_recal, st_engine} state_t;

endpackage

// [design/disk_command_decoder.sv]
// command interpreter: decodes six-byte command blocks, runs ready test,
// recalibrate and status report, hands other commands to a data engine
// assumes APB master on clk; drive status pins asynchronous to clk
`timescale 1ns/1ps
module disk_command_decoder #(
   parameter int STEP_CYCLES = disk_cmd_pkg::STEP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive status pins, one bit per unit
   input wire logic [7:0] drive_ready,
   input wire logic [7:0] drive_fault,
   input wire logic [7:0] seek_busy,
   input wire logic [7:0] track_zero,
   // drive control
   output logic [2:0] drive_select,
   output logic step,
   output logic step_outward,
   // data engine handoff
   output logic engine_start
);

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      disk_cmd_pkg::state_t state;
      logic [31:0] cmd_lo;
      logic [15:0] cmd_hi;
      logic [7:0] spt;
      logic [2:0] unit;
      logic engine;
      logic [19:0] div;
      logic [10:0] steps;
      logic step;
      logic outward;
      logic [5:0] last_err;
      logic [7:0] unit_avf;
      logic [7:0][5:0] unit_err;
      logic [7:0][20:0] unit_addr;
      logic [31:0] report;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dec_state_t;

   dec_state_t s;
   dec_state_t next_s;

   logic [7:0] rdy_s;
   logic [7:0] flt_s;
   logic [7:0] sbusy_s;
   logic [7:0] trk0_s;

   pin_sync #(.WIDTH(32)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in({drive_ready, drive_fault, seek_busy, track_zero}),
      .sync_out({rdy_s, flt_s, sbusy_s, trk0_s})
   );

   // ************************************************
   // command block fields
   // ************************************************
   logic [2:0] cls;
   logic [4:0] op;
   logic [2:0] drive_unit_number;
   logic [7:0] cnt;
   logic [7:0] ctl;
   logic flex;
   logic known;
   logic flex_ok;
   logic fixed_ok;
   logic needs_addr;
   logic fmt_beyond;
   logic is_fmt;
   logic [8:0] blocks;

   assign cls = s.cmd_lo[7:5];
   assign op = s.cmd_lo[4:0];
   assign drive_unit_number = s.cmd_lo[15:13];
   assign cnt = s.cmd_hi[7:0];
   assign ctl = s.cmd_hi[15:8];
   assign flex = (drive_unit_number == disk_cmd_pkg::FLEX_UNIT_A) || (drive_unit_number == disk_cmd_pkg::FLEX_UNIT_B);
   assign blocks = (cnt == 8'h00) ? disk_cmd_pkg::BLOCK_FULL : {1'b0, cnt};

   // which commands exist, which unit types accept them
   always_comb begin
      known = 1'b0;
      flex_ok = 1'b0;
      fixed_ok = 1'b1;
      needs_addr = 1'b0;
      fmt_beyond = 1'b0;
      is_fmt = 1'b0;
      if (cls == disk_cmd_pkg::CLASS_OPER) begin
         case (op)
            disk_cmd_pkg::OP_TEST_READY: begin
               known = 1'b1;
            end
            disk_cmd_pkg::OP_RECAL, disk_cmd_pkg::OP_STATUS, disk_cmd_pkg::OP_SET_PARAM: begin
               known = 1'b1;
               flex_ok = 1'b1;
            end
            disk_cmd_pkg::OP_FMT_DRIVE, disk_cmd_pkg::OP_FMT_ALT: begin
               known = 1'b1;
               needs_addr = 1'b1;
               fmt_beyond = 1'b1;
               is_fmt = 1'b1;
            end
            disk_cmd_pkg::OP_FMT_TRACK: begin
               known = 1'b1;
               flex_ok = 1'b1;
               needs_addr = 1'b1;
               fmt_beyond = 1'b1;
               is_fmt = 1'b1;
            end
            disk_cmd_pkg::OP_CHECK_FMT, disk_cmd_pkg::OP_FMT_BAD: begin
               known = 1'b1;
               needs_addr = 1'b1;
               is_fmt = 1'b1;
            end
            disk_cmd_pkg::OP_READ, disk_cmd_pkg::OP_WRITE, disk_cmd_pkg::OP_SEEK: begin
               known = 1'b1;
               flex_ok = 1'b1;
               needs_addr = 1'b1;
            end
            disk_cmd_pkg::OP_BURST_LEN, disk_cmd_pkg::OP_BUF_WRITE,
            disk_cmd_pkg::OP_BUF_READ: begin
               known = 1'b1;
            end
            default: begin
               known = 1'b0;
            end
         endcase
      end else if (cls == disk_cmd_pkg::CLASS_DIAG) begin
         case (op)
            disk_cmd_pkg::DG_MEMORY, disk_cmd_pkg::DG_CTRL: begin
               known = 1'b1;
               flex_ok = 1'b1;
            end
            disk_cmd_pkg::DG_DRIVE: begin
               known = 1'b1;
            end
            disk_cmd_pkg::DG_READ_EXT, disk_cmd_pkg::DG_WRITE_EXT: begin
               known = 1'b1;
               needs_addr = 1'b1;
            end
            default: begin
               known = 1'b0;
            end
         endcase
      end
      // buffer, memory and controller commands carry no unit, so any unit passes
      if ((cls == disk_cmd_pkg::CLASS_OPER && (op == disk_cmd_pkg::OP_BUF_WRITE ||
            op == disk_cmd_pkg::OP_BUF_READ)) || (cls == disk_cmd_pkg::CLASS_DIAG &&
            (op == disk_cmd_pkg::DG_MEMORY || op == disk_cmd_pkg::DG_CTRL))) begin
         flex_ok = 1'b1;
      end
      fixed_ok = known;
   end

   // ************************************************
   // status word for software
   // ************************************************
   logic [31:0] stat_word;
   logic retry_off;
   logic ecc_single;
   logic fill_buffer;
   logic [1:0] size_code;

   assign retry_off = !flex && ctl[disk_cmd_pkg::CTL_RETRY];
   assign ecc_single = !flex && ctl[disk_cmd_pkg::CTL_ECC];
   assign fill_buffer = !flex && is_fmt && ctl[disk_cmd_pkg::CTL_FILL];
   assign size_code = flex ? ctl[disk_cmd_pkg::CTL_SS_LSB +: 2] : 2'h0;

   // retry, ECC, fill and size bits that do not apply read as zero; ctl[3:0] and the block count always pass
   always_comb begin
      stat_word = '0;
      stat_word[0] = (s.state != disk_cmd_pkg::st_idle);
      stat_word[1] = s.engine;
      stat_word[2] = flex;
      stat_word[3] = retry_off;
      stat_word[4] = ecc_single;
      stat_word[5] = fill_buffer;
      stat_word[7:6] = size_code;
      stat_word[11:8] = ctl[3:0];
      stat_word[20:12] = blocks;
      stat_word[26:21] = s.last_err;
      stat_word[27] = needs_addr;
   end

   // ************************************************
   // next state
   // ************************************************
   logic acc;
   logic wr;
   logic rd;
   logic go;
   logic tick;
   logic [5:0] done_err;
   logic [20:0] done_addr;
   logic [5:0] res_err;
   logic res_store;

   assign acc = psel && penable && !s.pready;
   assign wr = psel && penable && s.pready && pwrite;
   assign rd = acc && !pwrite;
   assign tick = (s.div == 20'(STEP_CYCLES - 1));
   assign done_err = pwdata[29:24];
   assign done_addr = pwdata[20:0];

   always_comb begin
      next_s = s;
      go = 1'b0;
      res_err = disk_cmd_pkg::ERR_NONE;
      res_store = 1'b0;
      next_s.pready = acc;
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      if (acc) begin
         case (paddr)
            disk_cmd_pkg::ADDR_CMD_LO: next_s.prdata = s.cmd_lo;
            disk_cmd_pkg::ADDR_CMD_HI: next_s.prdata = {16'h0000, s.cmd_hi};
            disk_cmd_pkg::ADDR_CTRL: next_s.prdata = '0;
            disk_cmd_pkg::ADDR_STAT: next_s.prdata = stat_word;
            disk_cmd_pkg::ADDR_DONE: next_s.prdata = '0;
            disk_cmd_pkg::ADDR_SPT: next_s.prdata = {24'h000000, s.spt};
            disk_cmd_pkg::ADDR_REPORT: next_s.prdata = s.report;
            default: next_s.pslverr = 1'b1;
         endcase
         if (!rd) begin
            next_s.prdata = '0;
         end
      end
      if (wr) begin
         case (paddr)
            disk_cmd_pkg::ADDR_CMD_LO: begin
               if (s.state == disk_cmd_pkg::st_idle) next_s.cmd_lo = pwdata;
            end
            disk_cmd_pkg::ADDR_CMD_HI: begin
               if (s.state == disk_cmd_pkg::st_idle) next_s.cmd_hi = pwdata[15:0];
            end
            disk_cmd_pkg::ADDR_CTRL: go = pwdata[0] && (s.state == disk_cmd_pkg::st_idle);
            disk_cmd_pkg::ADDR_SPT: next_s.spt = pwdata[7:0];
            default: begin
            end
         endcase
      end

      next_s.step = 1'b0;
      case (s.state)
         disk_cmd_pkg::st_idle: begin
            if (go) begin
               next_s.unit = drive_unit_number;
               if (!known || (flex && !flex_ok) || (!flex && !fixed_ok)) begin
                  res_err = disk_cmd_pkg::ERR_INVALID;
                  res_store = 1'b1;
               end else if (cls == disk_cmd_pkg::CLASS_OPER &&
                     op == disk_cmd_pkg::OP_STATUS) begin
                  // status request leaves the unit's history untouched
                  next_s.report = {s.unit_addr[drive_unit_number][7:0], s.unit_addr[drive_unit_number][15:8], drive_unit_number,
                     s.unit_addr[drive_unit_number][20:16], s.unit_avf[drive_unit_number], 1'b0,
                     s.unit_err[drive_unit_number]};
                  next_s.last_err = disk_cmd_pkg::ERR_NONE;
               end else if (cls == disk_cmd_pkg::CLASS_OPER &&
                     op == disk_cmd_pkg::OP_TEST_READY) begin
                  res_store = 1'b1;
                  if (flt_s[drive_unit_number]) res_err = disk_cmd_pkg::ERR_FAULT;
                  else if (!rdy_s[drive_unit_number]) res_err = disk_cmd_pkg::ERR_NOT_READY;
                  else if (sbusy_s[drive_unit_number]) res_err = disk_cmd_pkg::ERR_SEEK_BUSY;
               end else if (cls == disk_cmd_pkg::CLASS_OPER &&
                     op == disk_cmd_pkg::OP_RECAL) begin
                  if (flt_s[drive_unit_number]) begin
                     res_err = disk_cmd_pkg::ERR_FAULT;
                     res_store = 1'b1;
                  end else if (!rdy_s[drive_unit_number]) begin
                     res_err = disk_cmd_pkg::ERR_NOT_READY;
                     res_store = 1'b1;
                  end else begin
                     next_s.state = disk_cmd_pkg::st_recal;
                     // first pulse starts with the period so it is full length
                     next_s.step = !trk0_s[drive_unit_number];
                     next_s.div = '0;
                     next_s.steps = '0;
                  end
               end else begin
                  next_s.engine = 1'b1;
                  next_s.state = disk_cmd_pkg::st_engine;
               end
            end
         end
         disk_cmd_pkg::st_recal: begin
            // one step pulse at the head of each step period, outward only
            next_s.div = tick ? 20'h00000 : s.div + 20'h00001;
            next_s.step = !trk0_s[s.unit] && (next_s.div < 20'(disk_cmd_pkg::STEP_PULSE_CYC));
            if (trk0_s[s.unit]) begin
               res_store = 1'b1;
               next_s.step = 1'b0;
               next_s.state = disk_cmd_pkg::st_idle;
            end else if (tick) begin
               if (s.steps == (flex ? disk_cmd_pkg::MAX_STEPS_FLEX :
                     disk_cmd_pkg::MAX_STEPS_FIXED)) begin
                  res_err = disk_cmd_pkg::ERR_TRACK0;
                  res_store = 1'b1;
                  next_s.step = 1'b0;
                  next_s.state = disk_cmd_pkg::st_idle;
               end else begin
                  next_s.steps = s.steps + 11'h001;
               end
            end
         end
         disk_cmd_pkg::st_engine: begin
            if (wr && paddr == disk_cmd_pkg::ADDR_DONE) begin
               next_s.engine = 1'b0;
               next_s.state = disk_cmd_pkg::st_idle;
               next_s.last_err = done_err;
               next_s.unit_err[s.unit] = done_err;
               next_s.unit_avf[s.unit] = needs_addr;
               if (done_err == disk_cmd_pkg::ERR_NONE && fmt_beyond) begin
                  next_s.unit_addr[s.unit] = done_addr + {13'h0000, s.spt};
               end else begin
                  next_s.unit_addr[s.unit] = done_addr;
               end
            end
         end
         default: begin
            next_s.state = disk_cmd_pkg::st_idle;
         end
      endcase

      next_s.outward = (next_s.state == disk_cmd_pkg::st_recal);
      if (res_store) begin
         next_s.last_err = res_err;
         next_s.unit_err[next_s.unit] = res_err;
         next_s.unit_avf[next_s.unit] = 1'b0;
         next_s.unit_addr[next_s.unit] = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.spt <= disk_cmd_pkg::SPT_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign drive_select = s.unit;
   assign step = s.step;
   assign step_outward = s.outward;
   assign engine_start = s.engine;
endmodule

// [design/pin_sync.sv]
// two-flop synchroniser for a group of level inputs from drive pins
// assumes inputs are slow levels; no pulse narrower than two clocks
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   always_comb begin
      next_s.meta = async_in;
      next_s.held = s.meta;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.held;
endmodule

// [verif/disk_cmd_monitor.sv]
// port checker for the disk command decoder
// assumes a bind onto disk_command_decoder; one clock domain
`timescale 1ns/1ps
module disk_cmd_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // drive control and engine
   input wire logic step,
   input wire logic step_outward,
   input wire logic engine_start
);
   logic [5:0] hi_cnt;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_first;
      psel && penable && !pready;
   endsequence
   sequence s_done_wr;
      psel && penable && pwrite && pready && paddr == disk_cmd_pkg::ADDR_DONE;
   endsequence
   // length of the present step pulse, drops back to zero after reaching 63
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt <= 6'h00;
      end else begin
         hi_cnt <= (step && hi_cnt != 6'h3F) ? hi_cnt + 6'h01 : 6'h00;
      end
   end
   a_access_answer: assert property (s_first |=> pready)
      else $error("no answer one cycle after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h00000000)
      else $error("prdata not zero outside answer");
   a_unmapped_err: assert property (s_first ##0 (paddr > 8'h18) |=> pslverr)
      else $error("unmapped access not refused");
   a_step_in_recal: assert property (step |-> step_outward)
      else $error("step outside recalibrate");
   a_step_short: assert property (step |-> hi_cnt < 6'd40)
      else $error("step pulse too long");
   a_step_full: assert property ($fell(step) && step_outward |-> hi_cnt == 6'd40)
      else $error("step pulse too short");
   a_engine_hold: assert property (engine_start && !pready |=> engine_start)
      else $error("engine start dropped early");
   a_engine_release: assert property (s_done_wr ##0 engine_start |=> !engine_start)
      else $error("engine start kept after done");
endmodule

// [verif/drive_bank_model.sv]
// behavioural bank of eight drives: status levels and head position
// assumes one recalibrate at a time; the bench sets the status levels
`timescale 1ns/1ps
module drive_bank_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // from the decoder
   input wire logic [2:0] drive_select,
   input wire logic step,
   input wire logic step_outward,
   // scenario settings
   input wire logic [7:0] rdy_cfg,
   input wire logic [7:0] flt_cfg,
   input wire logic [7:0] bsy_cfg,
   input wire logic [10:0] zero_after,
   // status pins
   output logic [7:0] drive_ready,
   output logic [7:0] drive_fault,
   output logic [7:0] seek_busy,
   output logic [7:0] track_zero
);
   logic [10:0] steps;
   logic step_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         steps <= 11'h000;
         step_q <= 1'b0;
      end else begin
         step_q <= step;
         if (!step_outward) begin
            steps <= 11'h000;
         end else if (step && !step_q) begin
            steps <= steps + 11'h001;
         end
      end
   end
   // zero_after of 0 is a drive whose track-zero sensor never answers
   assign track_zero = (zero_after != 11'h000 && steps >= zero_after) ?
                       (8'h01 << drive_select) : 8'h00;
   assign drive_ready = rdy_cfg;
   assign drive_fault = flt_cfg;
   assign seek_busy = bsy_cfg;
endmodule

// [verif/tb_disk_command_decoder.sv]
// self-checking bench for the disk command decoder over apb
// assumes drive_bank_model on the drive pins and a 40 MHz clock
`timescale 1ns/1ps
module tb_disk_command_decoder;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, step, step_outward, engine_start, er;
   logic [2:0] drive_select;
   logic [7:0] drive_ready, drive_fault, seek_busy, track_zero;
   logic [7:0] rdy_cfg = 8'hFE;
   logic [7:0] flt_cfg = 8'h04;
   logic [7:0] bsy_cfg = 8'h02;
   logic [10:0] zero_after = 11'h003;
   logic [5:0] rdy_err [4] = '{6'h04, 6'h08, 6'h03, 6'h00};
   logic [10:0] bad [8] = '{11'h300, 11'h010, 11'h048, 11'h088, 11'h3B8, 11'h004, 11'h39C,
                            11'h06D};
   logic [7:0] good [13] = '{8'h04, 8'h05, 8'h07, 8'h0B, 8'h0C, 8'h0D, 8'h0F, 8'h10,
                             8'hE0, 8'hE3, 8'hE4, 8'hE5, 8'hE6};
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   always #12.5 clk = ~clk;
   disk_command_decoder #(.STEP_CYCLES(60)) i_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drive_ready(drive_ready),
      .drive_fault(drive_fault), .seek_busy(seek_busy), .track_zero(track_zero),
      .drive_select(drive_select), .step(step), .step_outward(step_outward),
      .engine_start(engine_start));
   drive_bank_model i_drv (.clk(clk), .rst_b(rst_b), .drive_select(drive_select),
      .step(step), .step_outward(step_outward), .rdy_cfg(rdy_cfg), .flt_cfg(flt_cfg),
      .bsy_cfg(bsy_cfg), .zero_after(zero_after), .drive_ready(drive_ready),
      .drive_fault(drive_fault), .seek_busy(seek_busy), .track_zero(track_zero));
   // ****************************************
   // tasks
   // ****************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until pready is seen at an edge, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // pready ends this wait; if it never comes, only the cycle ceiling does
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic [7:0] co, input logic [2:0] u, input logic [20:0] a,
                      input logic [7:0] n, input logic [7:0] k);
      apb(1'b1, disk_cmd_pkg::ADDR_CMD_LO, {a[7:0], a[15:8], u, a[20:16], co});
      apb(1'b1, disk_cmd_pkg::ADDR_CMD_HI, {16'h0000, k, n});
      apb(1'b1, disk_cmd_pkg::ADDR_CTRL, 32'h00000001);
   endtask
   task automatic rep(input logic [2:0] u, input logic v, input logic [5:0] e,
                      input logic [20:0] a);
      cmd(8'h03, u, 21'h000000, 8'h00, 8'h00);
      apb(1'b0, disk_cmd_pkg::ADDR_REPORT, 32'h00000000);
      chk(rd, {a[7:0], a[15:8], u, a[20:16], v, 1'b0, e});
   endtask
   task automatic eng(input logic [5:0] e, input logic [20:0] a);
      chk({31'h00000000, engine_start}, 32'h00000001);
      apb(1'b1, disk_cmd_pkg::ADDR_DONE, {2'h0, e, 3'h0, a});
      chk({31'h00000000, engine_start}, 32'h00000000);
   endtask
   task automatic wait_idle();
      rd = 32'h00000001;
      while (rd[0] !== 1'b0) begin
         apb(1'b0, disk_cmd_pkg::ADDR_STAT, 32'h00000000);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         complete_run();
      end
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, disk_cmd_pkg::ADDR_SPT, 32'h00000000);
      chk(rd, 32'h00000011);
      apb(1'b0, disk_cmd_pkg::ADDR_STAT, 32'h00000000);
      chk(rd, 32'h00100000);
      apb(1'b0, 8'h1C, 32'h00000000);
      chk({er, rd[30:0]}, 32'h80000000);
      for (int u = 0; u < 4; u++) begin
         cmd(8'h00, u[2:0], 21'h000000, 8'h00, 8'h00);
         rep(u[2:0], 1'b0, rdy_err[u], 21'h000000);
      end
      // reserved class, undefined op codes, unit types refused
      for (int i = 0; i < 8; i++) begin
         cmd(bad[i][10:3], bad[i][2:0], 21'h000000, 8'h00, 8'h00);
         chk({31'h00000000, engine_start}, 32'h00000000);
         rep(bad[i][2:0], 1'b0, 6'h32, 21'h000000);
      end
      for (int i = 0; i < 13; i++) begin
         cmd(good[i], 3'h3, 21'h000100, 8'h01, 8'h00);
         eng(6'h00, 21'h000100);
      end
      cmd(8'h08, 3'h3, 21'h1ABCDE, 8'h00, 8'hE5);
      apb(1'b0, disk_cmd_pkg::ADDR_STAT, 32'h00000000);
      chk(rd & 32'h081FFF1E, 32'h0810051A);
      eng(6'h00, 21'h1ABCE2);
      rep(3'h3, 1'b1, 6'h00, 21'h1ABCE2);
      apb(1'b1, disk_cmd_pkg::ADDR_SPT, 32'h00000020);
      apb(1'b0, disk_cmd_pkg::ADDR_SPT, 32'h00000000);
      chk(rd, 32'h00000020);
      cmd(8'h06, 3'h3, 21'h000040, 8'h03, 8'h20);
      apb(1'b0, disk_cmd_pkg::ADDR_STAT, 32'h00000000);
      chk(rd & 32'h0000003C, 32'h00000020);
      eng(6'h00, 21'h000040);
      rep(3'h3, 1'b1, 6'h00, 21'h000060);
      // flexible unit: retry, ECC and fill bits are ignored, bits 5:4 give the size code
      cmd(8'h0A, 3'h4, 21'h012345, 8'h07, 8'hF3);
      apb(1'b0, disk_cmd_pkg::ADDR_STAT, 32'h00000000);
      chk(rd & 32'h081FFFFE, 32'h080073C6);
      eng(6'h17, 21'h012347);
      rep(3'h4, 1'b1, 6'h17, 21'h012347);
      cmd(8'h01, 3'h3, 21'h000000, 8'h00, 8'h00);
      chk({28'h0000000, step_outward, drive_select}, 32'h0000000B);
      wait_idle();
      rep(3'h3, 1'b0, 6'h00, 21'h000000);
      zero_after <= 11'h000;
      cmd(8'h01, 3'h5, 21'h000000, 8'h00, 8'h00);
      wait_idle();
      rep(3'h5, 1'b0, 6'h06, 21'h000000);
      complete_run();
   end
endmodule
bind disk_command_decoder disk_cmd_monitor i_mon (.clk(clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .step(step), .step_outward(step_outward),
   .engine_start(engine_start));
